// [hw/bmm_pkg.sv]
// package: constants and types for the banked memory map block
package bmm_pkg;
   // program memory and counter
   localparam int unsigned PC_W          = 13;             // program counter width
   localparam logic [12:0] RESET_VECTOR  = 13'h0000;       // fetch start after reset
   localparam logic [12:0] INT_VECTOR    = 13'h0004;       // fetch target on interrupt
   localparam logic [12:0] TOP_2K        = 13'h07ff;       // top address, 2K variant
   localparam logic [12:0] TOP_4K        = 13'h0fff;       // top address, 4K variant
   localparam logic [12:0] TOP_8K        = 13'h1fff;       // top address, 8K variant
   // data memory map, offsets within a bank
   localparam logic [6:0]  OFS_INDIRECT  = 7'h00;          // indirect access port
   localparam logic [6:0]  OFS_PCL       = 7'h02;          // program counter low
   localparam logic [6:0]  OFS_STATUS    = 7'h03;          // status flags
   localparam logic [6:0]  OFS_POINTER   = 7'h04;          // indirect pointer
   localparam logic [6:0]  OFS_PCLATCH   = 7'h0a;          // pc upper latch
   localparam logic [6:0]  OFS_INTCTL    = 7'h0b;          // interrupt control
   localparam logic [6:0]  OFS_GPR_BASE  = 7'h20;          // first general purpose byte
   localparam int unsigned BANK_BYTES    = 128;            // bytes per bank
   localparam int unsigned GPR_BANKS     = 2;              // banks holding general ram
   localparam int unsigned GPR_BYTES     = 96;             // general bytes per bank
   // status field positions
   localparam int unsigned BANK_LO_POS   = 5;              // bank_select_low
   localparam int unsigned BANK_HI_POS   = 6;              // bank_select_high
   localparam int unsigned IRP_POS       = 7;              // indirect bank high bit
   // reset values
   localparam logic [7:0]  STATUS_RST    = 8'h18;          // status after reset
   localparam logic [7:0]  ZERO_RST      = 8'h00;          // other registers after reset
   // pipeline phase states
   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} bmm_phase_t;
endpackage

// [hw/bmm_core.sv]
// module: data memory map, program counter and fetch pipeline of the core
// Function
// - one cycle per instruction, branches two
// - branch flushes prefetched instruction as no-op
// - thirteen bit program counter, 8K space
// - program memory spans zero to variant top
// - fetches above top wrap by masking
// - reset loads reset vector into counter
// - interrupt redirects fetch to fixed vector
// - two status bits select data bank
// - bank spans 128 bytes, offset plus bank
// - low offsets special registers, above general ram in banks 0 and 1
// - banks hold special registers, all mirrored in every bank
// - direct or pointer indirect register access
// - pc upper latch mirrored at 0Ah, 8Ah
// - interrupt control mirrored at 0Bh, 8Bh
// - unimplemented data locations read as zero
// - clock divided into four phases, pc increments first
// - operand read phase two, write phase four
`timescale 1ns/1ps
`default_nettype none
module bmm_core
   import bmm_pkg::*;
#(
   parameter logic [12:0] PROG_TOP = 13'h1fff             // variant top address
) (
   input  wire logic        clk,                          // 125 MHz clock
   input  wire logic        rst_n,                        // synchronous reset, low
   // execute side, from the instruction core
   input  wire logic        ex_branch,                    // executing instruction changes flow
   input  wire logic [12:0] ex_target,                    // branch target address
   input  wire logic        ex_int_take,                  // interrupt accepted
   input  wire logic        ex_direct,                    // 1 direct address, 0 indirect through the pointer
   input  wire logic [6:0]  ex_addr,                      // direct offset within bank
   input  wire logic        ex_wr,                        // write destination
   input  wire logic [7:0]  ex_wdata,                     // destination data
   input  wire logic [13:0] prog_rdata,                   // fetched instruction word
   // to the core and program memory
   output logic [12:0]      prog_addr,                    // fetch address
   output logic             prog_rd,                      // fetch strobe, phase four
   output logic [13:0]      instr_q,                      // instruction register
   output logic             instr_nop,                    // executing a flushed slot
   output logic [7:0]       op_rdata,                     // operand read in phase two
   output logic [1:0]       phase,                        // current phase
   output logic [7:0]       status_o                      // status flags
);
   bmm_phase_t  ph_q;                                     // phase counter
   logic [12:0] pc_q;                                     // program counter
   logic [12:0] fetch_q;                                  // address of prefetch
   logic        flush_q;                                  // executing slot is a forced no-op
   logic [7:0]  status_q, pointer_q, pclatch_q, intctl_q; // shared special registers
   logic [7:0]  gpr_q [GPR_BANKS][GPR_BYTES];             // general purpose ram
   logic [13:0] instr_r;                                  // instruction register
   logic        nop_r;                                    // flushed slot flag
   logic [7:0]  rdata_r;                                  // operand register
   logic [12:0] paddr_r;                                  // program address register
   logic        prd_r;                                    // fetch strobe register
   logic [8:0]  eff_addr;                                 // bank plus offset
   logic [12:0] pc_mask;                                  // variant wrap mask

   assign pc_mask = PROG_TOP;

   // effective address: direct uses bank bits, indirect the pointer
   function automatic logic [8:0] eff_calc(input logic dir, input logic [6:0] a,
                                           input logic [7:0] st, input logic [7:0] ptr);
      if (dir && a != OFS_INDIRECT)
         eff_calc = {st[BANK_HI_POS], st[BANK_LO_POS], a};
      else
         eff_calc = {st[IRP_POS], ptr};
   endfunction

   // map lookup: a zero read for any hole in the map
   function automatic logic [7:0] map_read(input logic [8:0] ea, input logic [7:0] st,
                                           input logic [7:0] ptr, input logic [7:0] lat,
                                           input logic [7:0] ic, input logic [12:0] pc,
                                           input logic [7:0] g0, input logic [7:0] g1);
      logic [6:0] o;
      o = ea[6:0];
      if (o == OFS_INDIRECT)
         map_read = 8'h00;                                 // pointer to itself reads zero
      else if (o == OFS_PCL)
         map_read = pc[7:0];
      else if (o == OFS_STATUS)
         map_read = st;
      else if (o == OFS_POINTER)
         map_read = ptr;
      else if (o == OFS_PCLATCH)
         map_read = lat;
      else if (o == OFS_INTCTL)
         map_read = ic;
      else if (o >= OFS_GPR_BASE && ea[8:7] == 2'b00)
         map_read = g0;
      else if (o >= OFS_GPR_BASE && ea[8:7] == 2'b01)
         map_read = g1;
      else
         map_read = 8'h00;
   endfunction

   logic [6:0] gidx;                                      // general ram index
   logic       gpr_hit;                                   // general ram access
   logic       is_wr_phase;                               // destination write slot
   assign eff_addr    = eff_calc(ex_direct, ex_addr, status_q, pointer_q);
   assign gidx        = eff_addr[6:0] - OFS_GPR_BASE;
   assign gpr_hit     = eff_addr[6:0] >= OFS_GPR_BASE && !eff_addr[8];
   assign is_wr_phase = ph_q == PH_FOUR && ex_wr && !flush_q;

   // phase counter: clock divided by four
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph_q <= PH_ONE;
      end else begin
         case (ph_q)
            PH_ONE:   ph_q <= PH_TWO;
            PH_TWO:   ph_q <= PH_THREE;
            PH_THREE: ph_q <= PH_FOUR;
            default:  ph_q <= PH_ONE;
         endcase
      end
   end

   // program counter: increments in phase one, redirected by flow change
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc_q    <= RESET_VECTOR;
         fetch_q <= RESET_VECTOR;
         // the first slot after reset holds no fetched word, so it runs empty;
         // this keeps flush_q and instr_nop telling the same story from reset on
         flush_q <= 1'b1;
      end else begin
         case (ph_q)
            PH_ONE: begin
               fetch_q <= pc_q & pc_mask;
               pc_q    <= (pc_q + 13'h0001) & pc_mask;
            end
            PH_FOUR: begin
               if (ex_int_take && !flush_q) begin
                  pc_q    <= INT_VECTOR;
                  flush_q <= 1'b1;
               end else if (ex_branch && !flush_q) begin
                  pc_q    <= ex_target & pc_mask;
                  flush_q <= 1'b1;
               end else if (is_wr_phase && ex_direct && ex_addr == OFS_PCL) begin
                  pc_q    <= {pclatch_q[4:0], ex_wdata} & pc_mask; // written low byte
                  flush_q <= 1'b1;
               end else begin
                  flush_q <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // fetch strobe and instruction register, fetched word latched in phase four
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         paddr_r <= RESET_VECTOR;
         prd_r   <= 1'b0;
         instr_r <= 14'h0000;
         nop_r   <= 1'b1;
      end else begin
         prd_r   <= ph_q == PH_THREE;
         paddr_r <= fetch_q;
         if (ph_q == PH_FOUR) begin
            instr_r <= prog_rdata;
            // next slot runs empty only after a flow change taken in a live slot;
            // a flushed slot cannot start a second flush behind it
            nop_r   <= !flush_q && (ex_int_take || ex_branch ||
                                    (is_wr_phase && ex_direct && ex_addr == OFS_PCL));
         end
      end
   end

   // operand read in phase two
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= ZERO_RST;
      end else if (ph_q == PH_TWO) begin
         rdata_r <= map_read(eff_addr, status_q, pointer_q, pclatch_q, intctl_q, pc_q,
                             gpr_q[0][gpr_hit ? gidx : 7'h00],
                             gpr_q[1][gpr_hit ? gidx : 7'h00]);
      end
   end

   // special register writes in phase four; shared registers decode in any bank
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q  <= STATUS_RST;
         pointer_q <= ZERO_RST;
         pclatch_q <= ZERO_RST;
         intctl_q  <= ZERO_RST;
      end else if (is_wr_phase) begin
         if (eff_addr[6:0] == OFS_STATUS)
            status_q <= ex_wdata;
         else if (eff_addr[6:0] == OFS_POINTER)
            pointer_q <= ex_wdata;
         else if (eff_addr[6:0] == OFS_PCLATCH)
            pclatch_q <= ex_wdata;
         else if (eff_addr[6:0] == OFS_INTCTL)
            intctl_q <= ex_wdata;
      end
   end

   // general purpose ram: holes beyond bank one are not stored
   always_ff @(posedge clk) begin
      if (is_wr_phase && gpr_hit && gidx < 7'(GPR_BYTES))
         gpr_q[eff_addr[7]][gidx] <= ex_wdata;
   end

   assign prog_addr = paddr_r;
   assign prog_rd   = prd_r;
   assign instr_q   = instr_r;
   assign instr_nop = nop_r;
   assign op_rdata  = rdata_r;
   assign phase     = ph_q;
   assign status_o  = status_q;

   // checks
   pc_reset_a: assert property (@(posedge clk) !rst_n |=> pc_q == RESET_VECTOR)
      else $error("pc not at reset vector");
   phase_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_ONE |=> ph_q == PH_TWO ##1 ph_q == PH_THREE ##1 ph_q == PH_FOUR)
      else $error("phase order broken");
   pc_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_ONE |=> pc_q == (($past(pc_q) + 13'h0001) & pc_mask))
      else $error("pc did not step");
   pc_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) (pc_q & ~pc_mask) == 13'h0)
      else $error("pc above top");
   int_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_FOUR && ex_int_take && !flush_q |=> pc_q == INT_VECTOR)
      else $error("interrupt vector missed");
   branch_nop_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_FOUR && ex_branch && !flush_q |=> instr_nop ##4 !instr_nop)
      else $error("flush slot wrong");
   status_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
      is_wr_phase && eff_addr[6:0] == OFS_STATUS |=> status_q == $past(ex_wdata))
      else $error("status write lost");
   hole_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_TWO && eff_addr[8] && eff_addr[6:0] >= OFS_GPR_BASE |=> op_rdata == 8'h00)
      else $error("hole not zero");
   // pointer keeps the written byte
   ptr_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      is_wr_phase && eff_addr[6:0] == OFS_POINTER |=> pointer_q == $past(ex_wdata))
      else $error("pointer write lost");
   // upper latch shared by all four banks
   latch_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      is_wr_phase && eff_addr[6:0] == OFS_PCLATCH |=> pclatch_q == $past(ex_wdata))
      else $error("latch write lost");
   // interrupt control shared by all four banks
   intctl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      is_wr_phase && eff_addr[6:0] == OFS_INTCTL |=> intctl_q == $past(ex_wdata))
      else $error("interrupt control write lost");
   // a flush lasts exactly one slot
   flush_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_FOUR && flush_q |=> !flush_q)
      else $error("flush not cleared");
   // a flushed slot leaves the status untouched
   flush_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_FOUR && flush_q |=> status_q == $past(status_q))
      else $error("flushed slot wrote");
   // fetch strobe stands exactly in phase four
   fetch_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
      prd_r == (ph_q == PH_FOUR))
      else $error("fetch strobe misplaced");
   // fetch address taken from the counter in phase one
   fetch_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_ONE |=> fetch_q == $past(pc_q))
      else $error("fetch address wrong");
   // program address stands while the strobe is up
   paddr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      prd_r |-> prog_addr == fetch_q)
      else $error("program address moved");
   // counter only moves in phases one and four
   pc_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_TWO || ph_q == PH_THREE |=> $stable(pc_q))
      else $error("pc moved mid cycle");
   // operand register only loads in phase two
   op_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q != PH_TWO |=> $stable(op_rdata))
      else $error("operand moved");
   // no-op flag only changes at the phase four edge
   nop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q != PH_FOUR |=> $stable(instr_nop))
      else $error("nop flag moved");
   // interrupt also empties the prefetched slot
   int_nop_a: assert property (@(posedge clk) disable iff (!rst_n)
      ph_q == PH_FOUR && ex_int_take && !flush_q |=> instr_nop)
      else $error("interrupt slot not flushed");
   // status only changes on a live destination write
   status_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !is_wr_phase |=> $stable(status_q))
      else $error("status changed unasked");
   fetch_b_c: cover property (@(posedge clk) disable iff (!rst_n) prd_r ##4 prd_r);
   branch_c:  cover property (@(posedge clk) disable iff (!rst_n) ex_branch && ph_q == PH_FOUR);
   irq_c:     cover property (@(posedge clk) disable iff (!rst_n) ex_int_take && ph_q == PH_FOUR);
   // counter low byte written as a computed jump
   pcl_c:     cover property (@(posedge clk) disable iff (!rst_n)
      is_wr_phase && ex_direct && ex_addr == OFS_PCL);
endmodule
`default_nettype wire

// [dv/bmm_prog_model.sv]
// program memory model that answers the fetch port of the core
`timescale 1ns/1ps
`default_nettype none
module bmm_prog_model (
   input  wire logic [12:0] prog_addr,    // fetch address from the block
   input  wire logic        prog_rd,      // fetch strobe, phase four
   output logic      [13:0] prog_rdata    // instruction word back
);
   // word is tied to its address, so a wrong fetch address shows up in instr_q;
   // off the strobe the inverse is driven, so a late or early sample never passes
   assign prog_rdata = prog_rd ? ({1'b1, prog_addr} ^ 14'h2a5a) : ~({1'b1, prog_addr} ^ 14'h2a5a);
endmodule
`default_nettype wire

// [dv/banked_memory_map_tb.sv]
// self-checking bench for the banked memory map core against a reference model
`timescale 1ns/1ps
`default_nettype none
module banked_memory_map_tb
   import bmm_pkg::*;
;
   localparam logic [12:0] TOP = TOP_2K;  // small variant so wraparound shows
   logic        clk, rst_n, ex_branch, ex_int_take, ex_direct, ex_wr, prog_rd, instr_nop;
   logic [12:0] ex_target, prog_addr;     // branch target, fetch address
   logic [6:0]  ex_addr;                  // operand offset
   logic [7:0]  ex_wdata, op_rdata, status_o;
   logic [13:0] prog_rdata, instr_q;      // instruction words
   logic [1:0]  phase;                    // current phase
   logic [7:0]  st_m, ptr_m, lat_m, ic_m; // model special registers
   logic [7:0]  gpr_m [int];              // model ram, only bytes written
   logic [12:0] fa_m, pfa_m;              // model fetch address, previous one
   logic        nop_m;                    // model: executing slot is flushed
   logic [31:0] r;                        // random draw
   logic [6:0]  o_r;                      // random ram offset
   int          miscompares, checks_done, seed, i;

   bmm_core #(.PROG_TOP(TOP)) uut (.clk(clk), .rst_n(rst_n), .ex_branch(ex_branch),
      .ex_target(ex_target), .ex_int_take(ex_int_take), .ex_direct(ex_direct),
      .ex_addr(ex_addr), .ex_wr(ex_wr), .ex_wdata(ex_wdata), .prog_rdata(prog_rdata),
      .prog_addr(prog_addr), .prog_rd(prog_rd), .instr_q(instr_q), .instr_nop(instr_nop),
      .op_rdata(op_rdata), .phase(phase), .status_o(status_o));
   bmm_prog_model prog_mem (.prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata));

   // free running clock, 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // verdict and end of run, the single exit point
   task automatic wrap_up();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one comparison, a mismatch is reported at once
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // reset held six cycles, model returns to its reset state
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      st_m = STATUS_RST;
      ptr_m = ZERO_RST;
      lat_m = ZERO_RST;
      ic_m = ZERO_RST;
      fa_m = RESET_VECTOR;
      nop_m = 1'b1;
      gpr_m.delete();
      chk("status_o", 16'(status_o), 16'(STATUS_RST));
      chk("phase", 16'(phase), 16'h0000);
   endtask

   // one instruction cycle: inputs held for four edges, checked against the model
   task automatic op(input logic br, input logic [12:0] tg, input logic it,
                     input logic [6:0] a, input logic w, input logic [7:0] d);
      logic [1:0] b;
      logic [6:0] o;
      logic [7:0] rv;
      logic       known;
      int         k;
      b = st_m[6:5];
      o = a;
      if (a == OFS_INDIRECT) begin  // pointer supplies bank and offset
         b = {st_m[IRP_POS], ptr_m[7]};
         o = ptr_m[6:0];
      end
      k = b * 128 + o;
      known = 1'b1;
      case (o)
         OFS_STATUS:  rv = st_m;
         OFS_POINTER: rv = ptr_m;
         OFS_PCLATCH: rv = lat_m;
         OFS_INTCTL:  rv = ic_m;
         default: begin  // ram; upper banks hold none and read zero
            known = gpr_m.exists(k) || b[1];
            rv = gpr_m.exists(k) ? gpr_m[k] : ZERO_RST;
         end
      endcase
      ex_branch = br;
      ex_target = tg;
      ex_int_take = it;
      ex_direct = 1'b1;
      ex_addr = a;
      ex_wr = w;
      ex_wdata = d;
      repeat (2) @(posedge clk);
      #1;
      chk("phase", 16'(phase), 16'h0002);
      chk("prog_rd", 16'(prog_rd), 16'h0000);
      chk("instr_nop", 16'(instr_nop), 16'(nop_m));
      if (!nop_m) chk("instr_q", 16'(instr_q), 16'({1'b1, pfa_m} ^ 14'h2a5a));
      if (!nop_m && known) chk("op_rdata", 16'(op_rdata), 16'(rv));
      @(posedge clk);
      #1;
      chk("prog_rd", 16'(prog_rd), 16'h0001);
      chk("prog_addr", 16'(prog_addr), 16'(fa_m));
      if (!nop_m && w) begin  // flushed slots write nothing
         case (o)
            OFS_STATUS:  st_m = d;
            OFS_PCL:     ;
            OFS_POINTER: ptr_m = d;
            OFS_PCLATCH: lat_m = d;
            OFS_INTCTL:  ic_m = d;
            default:     if (!b[1]) gpr_m[k] = d;
         endcase
      end
      pfa_m = fa_m;
      if (!nop_m && (it || br || (w && a == OFS_PCL))) begin  // interrupt wins over branch
         fa_m = it ? INT_VECTOR : br ? (tg & TOP) : ({lat_m[4:0], d} & TOP);
         nop_m = 1'b1;
      end else begin
         fa_m = (fa_m + 13'h0001) & TOP;
         nop_m = 1'b0;
      end
      @(posedge clk);
      #1;
      chk("status_o", 16'(status_o), 16'(st_m));
   endtask

   // watchdog so a stuck run still reaches the verdict
   initial begin
      #40000;
      miscompares++;
      wrap_up();
   end

   // main sequence
   initial begin
      {ex_branch, ex_target, ex_int_take, ex_direct, ex_addr, ex_wr, ex_wdata} = '0;
      {miscompares, checks_done} = '0;
      seed = 32'h36a3;
      pfa_m = RESET_VECTOR;
      do_reset();
      op(1'b1, 13'h0100, 1'b0, 7'h20, 1'b1, 8'h11);
      repeat (3) op(1'b0, 13'h0000, 1'b0, OFS_STATUS, 1'b0, 8'h00);
      for (i = 0; i < 4; i++) begin  // every bank code, ram only in banks 0 and 1
         op(1'b0, 13'h0000, 1'b0, OFS_STATUS, 1'b1, 8'(i << 5));
         op(1'b0, 13'h0000, 1'b0, 7'h40, 1'b1, 8'(8'h30 + i));
         op(1'b0, 13'h0000, 1'b0, 7'h40, 1'b0, 8'h00);
      end
      op(1'b0, 13'h0000, 1'b0, OFS_STATUS, 1'b1, 8'h00);
      op(1'b0, 13'h0000, 1'b0, 7'h40, 1'b0, 8'h00);
      op(1'b0, 13'h0000, 1'b0, OFS_PCLATCH, 1'b1, 8'h15);
      op(1'b0, 13'h0000, 1'b0, OFS_INTCTL, 1'b1, 8'h0c);
      op(1'b0, 13'h0000, 1'b0, OFS_PCL, 1'b1, 8'h3c);
      op(1'b0, 13'h0000, 1'b0, OFS_STATUS, 1'b1, 8'h20);
      op(1'b0, 13'h0000, 1'b0, OFS_PCLATCH, 1'b0, 8'h00);
      op(1'b0, 13'h0000, 1'b0, OFS_INTCTL, 1'b0, 8'h00);
      op(1'b0, 13'h0000, 1'b0, OFS_STATUS, 1'b0, 8'h00);
      op(1'b0, 13'h0000, 1'b0, OFS_POINTER, 1'b1, 8'ha5);
      op(1'b0, 13'h0000, 1'b0, OFS_INDIRECT, 1'b1, 8'h77);
      op(1'b0, 13'h0000, 1'b0, 7'h25, 1'b0, 8'h00);
      op(1'b1, 13'h0123, 1'b0, 7'h25, 1'b0, 8'h00);
      op(1'b1, 13'h0400, 1'b1, 7'h25, 1'b1, 8'h99);
      op(1'b0, 13'h0000, 1'b0, OFS_INDIRECT, 1'b0, 8'h00);
      op(1'b1, 13'h0200, 1'b1, 7'h25, 1'b0, 8'h00);
      op(1'b0, 13'h0000, 1'b0, 7'h25, 1'b0, 8'h00);
      op(1'b1, 13'h17ff, 1'b0, 7'h25, 1'b0, 8'h00);
      repeat (2) op(1'b0, 13'h0000, 1'b0, 7'h25, 1'b0, 8'h00);
      for (i = 0; i < 24; i++) begin  // random ram traffic, indirect write or read, direct read
         r = $random(seed);
         o_r = 7'h20 + 7'(r[14:8] % 96);
         op(1'b0, 13'h0000, 1'b0, OFS_POINTER, 1'b1, {r[3], o_r});
         op(1'b0, 13'h0000, 1'b0, OFS_INDIRECT, r[1], r[23:16]);
         op(1'b0, 13'h0000, 1'b0, OFS_STATUS, 1'b1, {2'b00, r[3], 5'h00});
         op(1'b0, 13'h0000, 1'b0, o_r, 1'b0, 8'h00);
      end
      do_reset();
      repeat (2) op(1'b0, 13'h0000, 1'b0, OFS_STATUS, 1'b0, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
